// ===== hw/awcs_device.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module awcs_device (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // link to the host controller
  awcs_link_if.device      link,
  // configuration from the feature commands
  input  wire logic        eightBitMode,
  input  wire logic        blockSizeSet,
  input  wire logic        blockEnabled,
  output logic [7:0]       identBlockSize,
  // media side
  output logic             mediaWordValid,
  output logic [15:0]      mediaWord,
  output logic             mediaSectorEnd,
  output logic [27:0]      mediaLba,
  output logic             mediaNoErase,
  input  wire logic        mediaReady,
  input  wire logic        mediaDone,
  input  wire logic        mediaError
);
  import awcs_pkg::*;

  // ========================================================================
  // pin synchronisers
  logic [20:0] pinMeta;
  logic [20:0] pinSync;
  logic        strobePrev;
  wire  [20:0] pinRaw = {link.tfAddr, link.dataBus, link.ioWriteStrobeN,
                         link.dmaGrantN};

  // two flops per pin; only the second stage is looked at
  always_ff @(posedge clock) begin
    if (rst) begin
      pinMeta <= 21'h000003;
      pinSync <= 21'h000003;
      strobePrev <= 1'b1;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
      strobePrev <= pinSync[1];
    end
  end

  // ========================================================================
  // task file registers and sequencer state
  awcs_dev_state_type state;
  logic [7:0]  feature;
  logic [7:0]  count;
  logic [7:0]  sector;
  logic [7:0]  cylLow;
  logic [7:0]  cylHigh;
  logic [7:0]  driveHead;
  logic [7:0]  errorReg;
  logic        busy;
  logic        data_request_bit;
  logic        err;
  logic        isDma;
  logic        isBlock;
  logic        firstSector;
  logic [8:0]  remaining;
  logic [7:0]  blockPos;
  logic [27:0] logical_addressing_select;
  logic        lastWord;

  // ========================================================================
  // link decode
  wire [2:0]  syncAddr = pinSync[20:18];
  wire [15:0] syncData = pinSync[17:2];
  wire        grantIdle = pinSync[0];
  wire        strobeRise = pinSync[1] && !strobePrev;
  wire        regWrite = strobeRise && grantIdle && (syncAddr != TF_DATA);
  wire        cmdWrite = regWrite && (syncAddr == TF_COMMAND);
  wire        pioWord = grantIdle && (syncAddr == TF_DATA);
  wire        dmaWord = !grantIdle && link.dmaRequestOut;
  wire        inXfer = (state == DS_XFER);
  wire        wordStrobe = strobeRise && inXfer &&
                           (isDma ? dmaWord : pioWord);
  wire        endOfSector = wordStrobe && lastWord;
  wire [7:0]  opcode = syncData[7:0];
  wire        opDma = (opcode == OP_WRITE_DMA);
  wire        opBlockNe = (opcode == OP_WRITE_BLOCK_NE);
  wire        opBlock = (opcode == OP_WRITE_BLOCK) || opBlockNe;
  wire        opSect = (opcode == OP_WRITE_SECT) ||
                       (opcode == OP_WRITE_SECT_RT);
  wire        driveMatch = (driveHead[DH_DRIVE] == DRIVE_ID);
  wire        blockRefused = opBlock && !(blockSizeSet && blockEnabled);
  wire        dmaRefused = opDma && eightBitMode;
  wire        refuse = !(opDma || opBlock || opSect) || blockRefused
                       || dmaRefused;
  // start address from the task file, address bits 27..0
  wire [27:0] startLba = {driveHead[3:0], cylHigh, cylLow, sector};
  wire [27:0] nextLba = logical_addressing_select + 28'h0000001;
  wire [8:0]  startCount = (count == 8'h00) ? MAX_SECTORS
                                            : {1'b0, count};
  wire        blockEnd = (blockPos == BLOCK_SECTORS - 8'h01);
  // DMA never interrupts per sector; sector writes skip the first one
  wire        raiseOnDrq = isBlock ? (blockPos == 8'h00)
                                   : (!isDma && !firstSector);
  wire [7:0]  statusByte = {busy, !busy, 4'h0, 1'b0, err} |
                           {4'h0, data_request_bit, 3'h0};
  wire [7:0]  readSel = (syncAddr == TF_FEATURE)   ? errorReg :
                        (syncAddr == TF_COUNT)     ? count :
                        (syncAddr == TF_SECTOR)    ? sector :
                        (syncAddr == TF_CYL_LOW)   ? cylLow :
                        (syncAddr == TF_CYL_HIGH)  ? cylHigh :
                        (syncAddr == TF_DRIVE_HEAD) ? driveHead :
                        (syncAddr == TF_COMMAND)   ? statusByte : 8'h00;

  // ========================================================================
  // word counter for the current sector
  awcs_word_counter awcs_word_counter_inst (
    .clock    (clock),
    .rst      (rst),
    .clear    (cmdWrite),
    .step     (wordStrobe),
    .lastWord (lastWord)
  );

  assign identBlockSize = BLOCK_SECTORS;
  assign link.devStatus = statusByte;

  // registered read-back of the selected task file byte
  always_ff @(posedge clock) begin
    if (rst) begin
      link.taskRead <= TF_RESET;
    end else begin
      link.taskRead <= readSel;
    end
  end

  // ========================================================================
  // command sequencer; task file writes are ignored while busy
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= DS_IDLE;
      {feature, sector, cylLow, cylHigh, driveHead} <= {5{TF_RESET}};
      count <= COUNT_RESET;
      errorReg <= TF_RESET;
      {busy, data_request_bit, err, isDma, isBlock, firstSector} <= 6'h00;
      remaining <= 9'h000;
      blockPos <= 8'h00;
      logical_addressing_select <= 28'h0000000;
      link.intrq <= 1'b0;
      link.dmaRequestOut <= 1'b0;
      mediaWordValid <= 1'b0;
      mediaWord <= 16'h0000;
      mediaSectorEnd <= 1'b0;
      mediaLba <= 28'h0000000;
      mediaNoErase <= 1'b0;
    end else begin
      mediaWordValid <= wordStrobe;
      mediaSectorEnd <= endOfSector;
      if (wordStrobe) begin
        mediaWord <= syncData;
      end
      case (state)
        DS_IDLE: begin
          if (regWrite && !cmdWrite) begin
            case (syncAddr)
              TF_FEATURE:  feature <= syncData[7:0];
              TF_COUNT:    count <= syncData[7:0];
              TF_SECTOR:   sector <= syncData[7:0];
              TF_CYL_LOW:  cylLow <= syncData[7:0];
              TF_CYL_HIGH: cylHigh <= syncData[7:0];
              default:     driveHead <= syncData[7:0];
            endcase
          end
          if (cmdWrite && driveMatch) begin
            link.intrq <= 1'b0;
            if (refuse) begin
              errorReg <= 8'(1 << ER_ABORT);
              err <= 1'b1;
              link.intrq <= 1'b1;
            end else begin
              errorReg <= TF_RESET;
              err <= 1'b0;
              busy <= 1'b1;
              state <= DS_PREP;
              isDma <= opDma;
              isBlock <= opBlock;
              mediaNoErase <= opBlockNe;
              firstSector <= 1'b1;
              remaining <= startCount;
              blockPos <= 8'h00;
              logical_addressing_select <= startLba;
              mediaLba <= startLba;
            end
          end
        end
        DS_PREP: begin
          // wait for buffer space before asking for data
          if (mediaReady) begin
            busy <= 1'b0;
            data_request_bit <= 1'b1;
            link.dmaRequestOut <= isDma;
            if (raiseOnDrq) begin
              link.intrq <= 1'b1;
            end
          end
          if (mediaReady) begin
            state <= DS_XFER;
          end
        end
        DS_XFER: begin
          if (endOfSector) begin
            busy <= 1'b1;
            data_request_bit <= 1'b0;
            link.dmaRequestOut <= 1'b0;
            link.intrq <= 1'b0;
            state <= DS_SECTOR;
          end
        end
        default: begin
          // failing sector: address stays, residual count reported
          if (mediaError) begin
            err <= 1'b1;
            errorReg <= 8'(1 << ER_MEDIA);
            busy <= 1'b0;
            count <= remaining[7:0];
            link.intrq <= 1'b1;
            state <= DS_IDLE;
          end else if (mediaDone) begin
            firstSector <= 1'b0;
            blockPos <= blockEnd ? 8'h00 : blockPos + 8'h01;
            if (remaining == 9'h001) begin
              busy <= 1'b0;
              count <= 8'h00;
              link.intrq <= 1'b1;
              state <= DS_IDLE;
            end else begin
              remaining <= remaining - 9'h001;
              logical_addressing_select <= nextLba;
              mediaLba <= nextLba;
              {driveHead[3:0], cylHigh, cylLow, sector} <= nextLba;
              state <= DS_PREP;
            end
          end
        end
      endcase
      // address registers track the sector in progress
      if (state == DS_SECTOR && (mediaError || mediaDone)
          && (mediaError || remaining == 9'h001)) begin
        {driveHead[3:0], cylHigh, cylLow, sector} <= logical_addressing_select;
      end
    end
  end

  // feature byte is stored but never read, TF_FEATURE reads return errorReg; mode bits come from ports
  wire unusedFeature = ^feature;
endmodule // awcs_device

// ===== shared/awcs_pkg.sv
// ==========================================================================
// shared constants for the write command sequencer
package awcs_pkg;
  // command opcodes
  localparam logic [7:0] OP_WRITE_DMA      = 8'hCA;
  localparam logic [7:0] OP_WRITE_BLOCK    = 8'hC5;
  localparam logic [7:0] OP_WRITE_BLOCK_NE = 8'hCD;
  localparam logic [7:0] OP_WRITE_SECT     = 8'h30;
  localparam logic [7:0] OP_WRITE_SECT_RT  = 8'h31;
  // task file register indices on the link address lines
  localparam logic [2:0] TF_DATA       = 3'h0;
  localparam logic [2:0] TF_FEATURE    = 3'h1;
  localparam logic [2:0] TF_COUNT      = 3'h2;
  localparam logic [2:0] TF_SECTOR     = 3'h3;
  localparam logic [2:0] TF_CYL_LOW    = 3'h4;
  localparam logic [2:0] TF_CYL_HIGH   = 3'h5;
  localparam logic [2:0] TF_DRIVE_HEAD = 3'h6;
  localparam logic [2:0] TF_COMMAND    = 3'h7;
  // status, error and drive/head field positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABORT = 2;
  localparam int ER_MEDIA = 6;
  localparam int DH_LBA = 6;
  localparam int DH_DRIVE = 4;
  // reset values of the task file
  localparam logic [7:0] TF_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h01;
  // sector and block geometry
  localparam logic [7:0] WORD_LAST = 8'hFF;
  localparam logic [8:0] MAX_SECTORS = 9'h100;
  localparam logic [7:0] BLOCK_SECTORS = 8'h01;
  localparam logic DRIVE_ID = 1'b0;
  // timing
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int STROBE_LOW_NS = 30;
  localparam int STROBE_GAP_NS = 40;
  localparam logic [3:0] STROBE_LOW_CYCLES =
    4'((STROBE_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [3:0] STROBE_GAP_CYCLES =
    4'((STROBE_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  // host controller register map (AXI4-Lite byte addresses)
  localparam logic [7:0] HR_TASK = 8'h00;
  localparam logic [7:0] HR_DATA = 8'h04;
  localparam logic [7:0] HR_CTRL = 8'h08;
  localparam logic [7:0] HR_STATUS = 8'h0C;
  localparam logic [7:0] HR_TASK_READ = 8'h10;
  localparam logic [3:0] CTRL_RESET = 4'hE;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // state machines
  typedef enum logic [1:0] {DS_IDLE, DS_PREP, DS_XFER, DS_SECTOR}
    awcs_dev_state_type;
  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_STROBE, HS_GAP}
    awcs_host_state_type;
endpackage

// ===== shared/awcs_link_if.sv
`timescale 1ns/1ps
// ==========================================================================
// link between host controller and storage device
interface awcs_link_if;
  logic [2:0]  tfAddr;
  logic [15:0] dataBus;
  logic        ioWriteStrobeN;
  logic        dmaGrantN;
  logic        dmaRequestOut;
  logic        intrq;
  logic [7:0]  devStatus;
  logic [7:0]  taskRead;
  modport device (
    input  tfAddr, dataBus, ioWriteStrobeN, dmaGrantN,
    output dmaRequestOut, intrq, devStatus, taskRead
  );
  modport host (
    output tfAddr, dataBus, ioWriteStrobeN, dmaGrantN,
    input  dmaRequestOut, intrq, devStatus, taskRead
  );
endinterface

// ===== hw/awcs_word_counter.sv
`timescale 1ns/1ps
// ==========================================================================
// counts 16-bit words inside one 512-byte sector
module awcs_word_counter (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // control
  input  wire logic       clear,
  input  wire logic       step,
  // state
  output logic            lastWord
);
  import awcs_pkg::*;
  logic [7:0] count;

  // wraps to zero after the last word, so no extra clear is needed
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      count <= 8'h00;
    end else if (step) begin
      count <= count + 8'h01;
    end
  end

  assign lastWord = (count == WORD_LAST);
endmodule // awcs_word_counter

// ===== hw/awcs_host.sv
`timescale 1ns/1ps
// ==========================================================================
// host controller: AXI4-Lite registers in, task file and data strobes out
module awcs_host (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link to the device
  awcs_link_if.host        link
);
  import awcs_pkg::*;

  // ========================================================================
  // state
  awcs_host_state_type state;
  logic [17:0] inMeta;
  logic [17:0] inSync;
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  ctrl;
  logic [3:0]  timer;

  // ========================================================================
  // decode
  wire        dmaMode = ctrl[0];
  wire [2:0]  readSelect = ctrl[3:1];
  wire [7:0]  statusSync = inSync[17:10];
  wire        reqSync = inSync[1];
  wire        both = awHeld && wHeld && !s_axi_bvalid;
  wire        isTask = (awAddr == HR_TASK);
  wire        isData = (awAddr == HR_DATA);
  wire        isCtrl = (awAddr == HR_CTRL);
  wire        engineIdle = (state == HS_IDLE);
  // strobe commands wait here while a strobe is under way
  wire        go = both && engineIdle && (isTask || isData);
  wire        finish = both && (engineIdle || !(isTask || isData));
  wire        slotOk = !statusSync[ST_BUSY] && statusSync[ST_DRQ];
  wire        readyToSend = dmaMode ? reqSync : slotOk;
  wire [31:0] readData =
    (s_axi_araddr == HR_CTRL) ? {28'h0, ctrl} :
    (s_axi_araddr == HR_STATUS) ? {22'h0, !engineIdle, inSync[0],
                                   statusSync} :
    (s_axi_araddr == HR_TASK_READ) ? {24'h0, inSync[9:2]} : 32'h0;
  wire        readHit = (s_axi_araddr == HR_CTRL) ||
                        (s_axi_araddr == HR_STATUS) ||
                        (s_axi_araddr == HR_TASK_READ);

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // device outputs pass two flops before use
  always_ff @(posedge clock) begin
    if (rst) begin
      inMeta <= 18'h00000;
      inSync <= 18'h00000;
    end else begin
      inMeta <= {link.devStatus, link.taskRead, link.dmaRequestOut,
                 link.intrq};
      inSync <= inMeta;
    end
  end

  // ========================================================================
  // AXI write and read channels
  always_ff @(posedge clock) begin
    if (rst) begin
      {awHeld, wHeld, s_axi_bvalid, s_axi_rvalid} <= 4'h0;
      awAddr <= 8'h00;
      wData <= 32'h0;
      ctrl <= CTRL_RESET;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        if (!s_axi_wstrb[0]) begin
          wData <= 32'h0;
        end
      end
      if (finish) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (isTask || isData || isCtrl) ? RESP_OKAY
                                                    : RESP_SLVERR;
        if (isCtrl) begin
          ctrl <= wData[3:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readData;
        s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // strobe engine: one task file byte or data word per command
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= HS_IDLE;
      timer <= 4'h0;
      link.tfAddr <= TF_COMMAND;
      link.dataBus <= 16'h0000;
      link.ioWriteStrobeN <= 1'b1;
      link.dmaGrantN <= 1'b1;
    end else begin
      case (state)
        HS_IDLE: begin
          link.tfAddr <= readSelect;
          if (go) begin
            link.tfAddr <= isTask ? wData[10:8] : TF_DATA;
            link.dataBus <= isTask ? {8'h00, wData[7:0]} : wData[15:0];
            state <= (isData) ? HS_WAIT : HS_STROBE;
            link.ioWriteStrobeN <= isData;
            timer <= 4'h1;
          end
        end
        HS_WAIT: begin
          // grant only while the device asks for data
          link.dmaGrantN <= !(dmaMode && reqSync);
          if (readyToSend) begin
            link.ioWriteStrobeN <= 1'b0;
            state <= HS_STROBE;
          end
        end
        HS_STROBE: begin
          timer <= timer + 4'h1;
          if (timer == STROBE_LOW_CYCLES) begin
            link.ioWriteStrobeN <= 1'b1;
            timer <= 4'h1;
            state <= HS_GAP;
          end
        end
        default: begin
          // gap outlasts the device sync delay so flags settle
          timer <= timer + 4'h1;
          if (timer == STROBE_GAP_CYCLES) begin
            link.dmaGrantN <= 1'b1;
            state <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule // awcs_host

// ===== verif/awcs_checker.sv
`timescale 1ns/1ps
// ==========================================================================
// link checks between the host controller and the device
module awcs_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // link signals
  input wire logic [2:0]  tfAddr,
  input wire logic [15:0] dataBus,
  input wire logic        ioWriteStrobeN,
  input wire logic        dmaGrantN,
  input wire logic        dmaRequestOut,
  input wire logic        intrq,
  input wire logic [7:0]  devStatus
);
  import awcs_pkg::*;
  logic [7:0] op;
  logic       firstDrq;
  wire cmdLow = !ioWriteStrobeN && dmaGrantN && tfAddr == TF_COMMAND;
  wire pio = op == OP_WRITE_SECT || op == OP_WRITE_SECT_RT;
  wire blk = op == OP_WRITE_BLOCK || op == OP_WRITE_BLOCK_NE;
  // opcode caught while the strobe is low, data is stable only then
  always_ff @(posedge clock) begin
    if (cmdLow) op <= dataBus[7:0];
    if (cmdLow) firstDrq <= 1'b1;
    else if (devStatus[ST_DRQ]) firstDrq <= 1'b0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence strobePulse;
    (!ioWriteStrobeN)[*6] ##1 ioWriteStrobeN;
  endsequence
  sequence drqStart;
    $rose(devStatus[ST_DRQ]);
  endsequence
  a_strobe_width: assert property ($fell(ioWriteStrobeN) |-> strobePulse)
    else $error("write strobe width wrong");
  a_busy_prompt: assert property ($rose(ioWriteStrobeN) && dmaGrantN &&
    tfAddr == TF_COMMAND |->
    ##[1:80] (devStatus[ST_BUSY] || devStatus[ST_ERR]))
    else $error("busy late after command");
  a_drq_unbusy: assert property (devStatus[ST_DRQ] |-> !devStatus[ST_BUSY])
    else $error("data request while busy");
  a_req_drq: assert property ($rose(dmaRequestOut) |-> devStatus[ST_DRQ])
    else $error("dma request without data request");
  a_drq_end: assert property ($fell(devStatus[ST_DRQ]) |->
    devStatus[ST_BUSY] || devStatus[ST_ERR])
    else $error("data request dropped without busy");
  a_dma_irq: assert property (op == OP_WRITE_DMA && $rose(intrq) |->
    !devStatus[ST_DRQ]) else $error("dma interrupt mid transfer");
  a_pio_first: assert property ((pio && firstDrq) ##0 drqStart |-> !intrq)
    else $error("interrupt before first sector");
  a_pio_next: assert property ((pio && !firstDrq) ##0 drqStart |->
    ##[0:2] intrq) else $error("no interrupt at next sector");
  a_block_irq: assert property (blk ##0 drqStart |-> ##[0:2] intrq)
    else $error("no interrupt at block start");
  a_irq_idle: assert property ($rose(intrq) |-> !devStatus[ST_BUSY])
    else $error("interrupt while busy");
  a_grant_req: assert property ($fell(dmaGrantN) |-> dmaRequestOut)
    else $error("grant without request");
endmodule // awcs_checker

// ===== verif/ata_write_command_sequencer_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// bench: host and device joined over the link, driven over AXI4-Lite
module ata_write_command_sequencer_tb;
  import awcs_pkg::*;
  localparam logic [7:0] OPS [5] = '{OP_WRITE_SECT, OP_WRITE_SECT_RT,
    OP_WRITE_BLOCK, OP_WRITE_BLOCK_NE, OP_WRITE_DMA};
  logic        clock = 1'b0, rst = 1'b1;
  logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0, last;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic        eightBitMode = 0, blockSizeSet = 1, blockEnabled = 1;
  logic        mediaReady = 1, mediaDone = 0, mediaError = 0, failNext = 0;
  wire         awReady, wReady, bValid, arReady, rValid;
  wire         mediaWordValid, mediaSectorEnd, mediaNoErase;
  wire [1:0]   rResp, bResp;
  wire [31:0]  rData;
  wire [15:0]  mediaWord;
  wire [27:0]  mediaLba;
  wire [7:0]   identBlockSize;
  int          n_mismatch = 0, tests_run = 0, seed = 68117;
  logic [33:0] rq[$], rm[$];
  logic [44:0] wq[$];
  always #2.5 clock = ~clock;
  awcs_link_if awcs_link_if_inst ();
  awcs_host awcs_host_inst (.clock(clock), .rst(rst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .link(awcs_link_if_inst));
  awcs_device awcs_device_inst (.clock(clock), .rst(rst),
    .link(awcs_link_if_inst), .eightBitMode(eightBitMode),
    .blockSizeSet(blockSizeSet), .blockEnabled(blockEnabled),
    .identBlockSize(identBlockSize), .mediaWordValid(mediaWordValid),
    .mediaWord(mediaWord), .mediaSectorEnd(mediaSectorEnd),
    .mediaLba(mediaLba), .mediaNoErase(mediaNoErase), .mediaReady(mediaReady),
    .mediaDone(mediaDone), .mediaError(mediaError));
  awcs_checker awcs_checker_inst (.clock(clock), .rst(rst),
    .tfAddr(awcs_link_if_inst.tfAddr), .dataBus(awcs_link_if_inst.dataBus),
    .ioWriteStrobeN(awcs_link_if_inst.ioWriteStrobeN),
    .dmaGrantN(awcs_link_if_inst.dmaGrantN),
    .dmaRequestOut(awcs_link_if_inst.dmaRequestOut),
    .intrq(awcs_link_if_inst.intrq), .devStatus(awcs_link_if_inst.devStatus));
  task automatic chk(input string what, input logic [44:0] e,
                     input logic [44:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic timeout(input string what);
    n_mismatch++;
    $display("ERROR %s expected answer seen timeout", what);
    conclude;
  endtask
  // each bus task waits one edge first so a released signal is not re-raised
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    do begin
      @(posedge clock);
      n++;
      if (awValid && awReady) awValid <= 0;
      if (wValid && wReady) wValid <= 0;
    end while (!(bValid && bReady) && n < 2000);
    bReady <= 0;
    if (n >= 2000) timeout("axi write");
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e,
                     input logic [33:0] m);
    int n = 0;
    rq.push_back(e & m);
    rm.push_back(m);
    @(posedge clock);
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do begin
      @(posedge clock);
      n++;
      last = rData;
      if (arValid && arReady) arValid <= 0;
    end while (!(rValid && rReady) && n < 2000);
    rReady <= 0;
    if (n >= 2000) timeout("axi read");
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] c,
                     input logic [27:0] l);
    axw(HR_CTRL, {28'h0, TF_COMMAND, op == OP_WRITE_DMA});
    axw(HR_TASK, {21'h0, TF_COUNT, c});
    axw(HR_TASK, {21'h0, TF_SECTOR, l[7:0]});
    axw(HR_TASK, {21'h0, TF_CYL_LOW, l[15:8]});
    axw(HR_TASK, {21'h0, TF_CYL_HIGH, l[23:16]});
    axw(HR_TASK, {21'h0, TF_DRIVE_HEAD, 4'hE, l[27:24]});
    axw(HR_TASK, {21'h0, TF_COMMAND, op});
  endtask
  // failure armed after word two: by then the previous sector has settled
  task automatic sector(input logic ne, input logic [27:0] l, input logic f);
    logic [15:0] w;
    for (int i = 0; i < 256; i++) begin
      w = 16'($random(seed));
      wq.push_back({ne, l, w});
      axw(HR_DATA, {16'h0, w});
      if (i == 1) failNext <= f;
    end
  endtask
  task automatic waitint;
    int n = 0;
    do begin
      axr(HR_STATUS, 34'h0, 34'h0);
      n++;
    end while (last[9:7] !== 3'b010 && n < 200);
    if (n >= 200) timeout("status");
  endtask
  task automatic tf(input logic [2:0] idx, input logic [7:0] e);
    axw(HR_CTRL, {28'h0, idx, 1'b0});
    repeat (8) @(posedge clock);
    axr(HR_TASK_READ, {26'h0, e}, 34'hFF);
  endtask
  // media stand-in answers every sector end, failing it when armed
  always @(posedge clock) begin
    mediaDone <= mediaSectorEnd && !failNext;
    mediaError <= mediaSectorEnd && failNext;
  end
  // watcher: oldest note against each read answer with a nonzero mask and each media word
  always @(posedge clock) begin
    if (rValid && rReady) begin
      if (rm[0] != 0) chk("read", 45'(rq[0]), 45'({rResp, rData} & rm[0]));
      void'(rq.pop_front());
      void'(rm.pop_front());
    end
    if (mediaWordValid) chk("media", wq.pop_front(),
                            {mediaNoErase, mediaLba, mediaWord});
  end
  initial begin
    logic [27:0] l;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("ident", 45'h1, {37'h0, identBlockSize});
    foreach (OPS[i]) begin
      l = 28'($random(seed));
      cmd(OPS[i], 8'h01, l);
      sector(OPS[i] == OP_WRITE_BLOCK_NE, l, 1'b0);
      waitint;
      axr(HR_STATUS, 34'h140, 34'h3C9);
      tf(TF_SECTOR, l[7:0]);
    end
    l = 28'($random(seed));
    cmd(OP_WRITE_SECT, 8'h03, l);
    sector(1'b0, l, 1'b0);
    sector(1'b0, l + 28'h1, 1'b1);
    waitint;
    tf(TF_FEATURE, 8'h40);
    tf(TF_COUNT, 8'h02);
    tf(TF_SECTOR, l[7:0] + 8'h01);
    failNext <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      eightBitMode <= k == 0;
      blockSizeSet <= k != 1;
      blockEnabled <= k != 2;
      cmd(k == 0 ? OP_WRITE_DMA : OP_WRITE_BLOCK, 8'h01, 28'h0);
      waitint;
      axr(HR_STATUS, 34'h141, 34'h3C9);
      tf(TF_FEATURE, 8'h04);
    end
    axr(8'h20, {RESP_SLVERR, 32'h0}, 34'h3FFFFFFFF);
    axw(8'h20, 32'h0);
    chk("bresp", 45'(RESP_SLVERR), 45'(bResp));
    conclude;
  end
endmodule // ata_write_command_sequencer_tb
